/* design/uart_pkg.sv */
// Shared constants, types and helpers for the serial port block
package uart_pkg;

    // Register offsets (byte addresses)
    localparam logic [7:0] OFS_DATA = 8'h00;
    localparam logic [7:0] OFS_FLAG = 8'h04;
    localparam logic [7:0] OFS_IBRD = 8'h08;
    localparam logic [7:0] OFS_FBRD = 8'h0c;
    localparam logic [7:0] OFS_LCR  = 8'h10;
    localparam logic [7:0] OFS_CTRL = 8'h14;
    localparam logic [7:0] OFS_ILPR = 8'h18;
    localparam logic [7:0] OFS_IFLS = 8'h1c;

    // Flag register bit that clears the sticky overrun on write
    localparam int unsigned FLAG_OVR_BIT = 5;

    // Bit-timing counts in oversample ticks, low-power clock periods and data bits
    localparam logic [3:0] SUB_LAST       = 4'hf;
    localparam logic [3:0] START_CHECK    = 4'h7;
    localparam logic [3:0] IR_NORMAL_SUBS = 4'h3;
    localparam logic [1:0] IR_LP_PERIODS  = 2'h3;
    localparam logic [2:0] DATA_LAST_BASE = 3'h4;

    typedef struct packed {
        logic       sps;
        logic [1:0] wlen;
        logic       fen;
        logic       stp2;
        logic       eps;
        logic       pen;
        logic       brk;
    } line_ctrl_t;

    typedef struct packed {
        logic [15:0] div_int;
        logic [5:0]  div_frac;
        line_ctrl_t  lcr;
    } cfg_t;

    typedef struct packed {
        logic receive_enable;
        logic transmit_enable;
        logic ir_lowpower;
        logic infrared_codec;
        logic global_enable;
    } ctrl_t;

    typedef struct packed {
        logic       overrun;
        logic       brk;
        logic       perr;
        logic       ferr;
        logic [7:0] data;
    } rx_entry_t;

    typedef enum logic [2:0] {TX_IDLE, TX_START, TX_DATA, TX_PARITY, TX_STOP} tx_state_t;
    typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_PARITY, RX_STOP, RX_BREAK} rx_state_t;

    localparam cfg_t       CFG_RESET  = '0;
    localparam ctrl_t      CTRL_RESET = 5'h18;
    localparam logic [7:0] ILPR_RESET = 8'h01;
    localparam logic [5:0] IFLS_RESET = 6'h12;

    // Parity over the active data bits; stick parity sends the inverse of eps
    function automatic logic parity_bit(input logic [7:0] d, input line_ctrl_t lc);
        logic [7:0] m;
        m = d & (8'hff >> (~lc.wlen));
        return lc.sps ? ~lc.eps : (lc.eps ? ^m : ~^m);
    endfunction : parity_bit

endpackage : uart_pkg

/* design/uart_serial.sv */
// Serial port with FIFOs, fractional baud generator, infrared codec and AHB-Lite registers
// What this block does
// [R01] Transmit and receive enables set after reset
// [R02] Disabling finishes the current character first
// [R03] Software disables before changing configuration
// [R04] Frame: start, data LSB first, parity, stops
// [R05] Receive only after valid start pulse
// [R06] Error and break flags stored with words
// [R07] Five to eight data bits
// [R08] Even, odd, stick or no parity
// [R09] One or two stop bits
// [R10] Sixteen by eight transmit, sixteen by twelve receive FIFOs
// [R11] FIFO off gives one-entry holding register
// [R12] Trigger levels one eighth to seven eighths
// [R13] Force and detect line break
// [R14] Divisor: 16-bit integer, 6-bit fraction
// [R15] Divisor is clock over sixteen times baud
// [R16] Software rounds fraction times 64
// [R17] Oversample tick at sixteen times baud
// [R18] 30-bit setting latched on line-control write
// [R19] Write divisors, then line control
// [R20] Selectable infrared codec up to 115.2k
// [R21] Normal 3/16 and low-power pulse widths
// [R22] Low-power clock divider 1 to 256
// [R23] Start accepted if low on eighth tick
// [R24] Sample every sixteenth tick; check stop
// [R25] Infrared zero is 3/16 high pulse
// [R26] Busy while FIFO non-empty or shifting
// [R27] Serial input passes two flip-flops
//
// Our own choices: the register addresses and the AHB-Lite register port.
`timescale 1ns/10ps

module fifo_buf #(
    parameter int unsigned W     = 8,
    parameter int unsigned DEPTH = 16
) (
    input  wire logic                       hclk,
    input  wire logic                       hresetn,
    input  wire logic                       one_deep,
    input  wire logic                       push,
    input  wire logic [W-1:0]               wdata,
    input  wire logic                       pop,
    output logic      [W-1:0]               rdata,
    output logic      [$clog2(DEPTH):0]     count,
    output logic                            full,
    output logic                            empty
);
    localparam int unsigned AW = $clog2(DEPTH);

    logic [W-1:0]  mem [DEPTH];
    logic [AW-1:0] wp_ff;
    logic [AW-1:0] rp_ff;
    logic [AW:0]   cnt_ff;

    wire [AW:0] cap     = one_deep ? (AW+1)'(1) : (AW+1)'(DEPTH);  // [R11]
    wire        do_push = push && !full;
    wire        do_pop  = pop && !empty;

    assign full  = cnt_ff >= cap;
    assign empty = cnt_ff == '0;
    assign count = cnt_ff;
    assign rdata = mem[rp_ff];

    always_ff @(posedge hclk) begin
        if (do_push) begin
            mem[wp_ff] <= wdata;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wp_ff  <= '0;
            rp_ff  <= '0;
            cnt_ff <= '0;
        end else begin
            wp_ff  <= do_push ? AW'(wp_ff + 1'b1) : wp_ff;
            rp_ff  <= do_pop ? AW'(rp_ff + 1'b1) : rp_ff;
            cnt_ff <= (AW+1)'(cnt_ff + {AW'(0), do_push} - {AW'(0), do_pop});
        end
    end
endmodule : fifo_buf

module uart_serial
    import uart_pkg::*;
#(
    parameter int unsigned DEPTH  = 16,
    parameter int unsigned ADDR_W = 12
) (
    input  wire logic              hclk,
    input  wire logic              hresetn,
    input  wire logic              hsel,
    input  wire logic [ADDR_W-1:0] haddr,
    input  wire logic              hwrite,
    input  wire logic [1:0]        htrans,
    input  wire logic [2:0]        hsize,
    input  wire logic              hready,
    input  wire logic [31:0]       hwdata,
    output logic      [31:0]       hrdata,
    output logic                   hreadyout,
    output logic                   hresp,
    input  wire logic              serial_in,
    output logic                   serial_out
);
    localparam int unsigned CW = $clog2(DEPTH) + 1;

    // Bus and register state
    logic [7:0]  wa_ff;
    logic        wr_pend_ff;
    logic [31:0] rdata_ff;
    logic [15:0] ibrd_ff;
    logic [5:0]  fbrd_ff;
    cfg_t        cfg_ff;
    ctrl_t       ctrl_ff;
    logic [7:0]  ilpr_ff;
    logic [5:0]  ifls_ff;
    logic        ovr_sticky_ff;

    // Baud and serial state
    logic [15:0] bcnt_ff;
    logic [5:0]  bacc_ff;
    logic [7:0]  lpcnt_ff;
    logic [1:0]  lp_pulse_ff;
    logic        rx_s1_ff;
    logic        rx_s2_ff;
    logic [3:0]  ir_hold_ff;
    logic        serial_out_ff;
    tx_state_t   tx_state_ff;
    logic [3:0]  tx_sub_ff;
    logic [2:0]  tx_bitn_ff;
    logic [7:0]  tx_shift_ff;
    logic        tx_par_ff;
    logic        tx_stopn_ff;
    rx_state_t   rx_state_ff;
    logic [3:0]  rx_sub_ff;
    logic [2:0]  rx_bitn_ff;
    logic [7:0]  rx_shift_ff;
    logic        rx_perr_ff;
    logic        rx_pbit_ff;
    logic        ovr_pend_ff;

    // FIFO wires
    logic [7:0]    tx_rdata;
    logic [CW-1:0] tx_count;
    logic          tx_full;
    logic          tx_empty;
    rx_entry_t     rx_rdata;
    logic [CW-1:0] rx_count;
    logic          rx_full;
    logic          rx_empty;
    logic          tx_pop;
    logic          rx_push;
    rx_entry_t     rx_entry;

    // Address phase capture; zero wait states
    wire       accept  = hsel && hready && htrans[1];
    wire       mapped  = haddr[ADDR_W-1:8] == '0;
    wire [7:0] ofs     = mapped ? haddr[7:0] : 8'hff;
    wire       rd_acc  = accept && !hwrite;
    wire       wr_now  = wr_pend_ff;
    wire       wr_data = wr_now && wa_ff == OFS_DATA;
    wire       wr_flag = wr_now && wa_ff == OFS_FLAG;
    wire       wr_ibrd = wr_now && wa_ff == OFS_IBRD;
    wire       wr_fbrd = wr_now && wa_ff == OFS_FBRD;
    wire       wr_lcr  = wr_now && wa_ff == OFS_LCR;
    wire       wr_ctrl = wr_now && wa_ff == OFS_CTRL;
    wire       wr_ilpr = wr_now && wa_ff == OFS_ILPR;
    wire       wr_ifls = wr_now && wa_ff == OFS_IFLS;
    wire       rd_pop  = rd_acc && ofs == OFS_DATA;

    // Fill-level triggers, in entries of the full FIFO
    function automatic logic [CW-1:0] trig_level(input logic [2:0] sel);
        logic [3:0] num;
        num = (sel == 3'h0) ? 4'h1 : (sel == 3'h1) ? 4'h2 : (sel == 3'h3) ? 4'h6 : (sel == 3'h4) ? 4'h7 : 4'h4;
        return CW'((DEPTH * num) / 8);
    endfunction : trig_level

    wire busy    = !tx_empty || tx_state_ff != TX_IDLE;  // [R26]
    wire tx_trig = tx_count <= trig_level(ifls_ff[2:0]);  // [R12]
    wire rx_trig = rx_count >= trig_level(ifls_ff[5:3]);  // [R12]

    wire [31:0] flag_word = {24'h0, rx_trig, tx_trig, ovr_sticky_ff, busy, rx_full, tx_empty, rx_empty, tx_full};
    wire [31:0] data_word = rx_empty ? 32'h0 : {20'h0, rx_rdata};
    wire [31:0] rd_word   = (ofs == OFS_DATA) ? data_word :
                            (ofs == OFS_FLAG) ? flag_word :
                            (ofs == OFS_IBRD) ? {16'h0, ibrd_ff} :
                            (ofs == OFS_FBRD) ? {26'h0, fbrd_ff} :
                            (ofs == OFS_LCR)  ? {24'h0, cfg_ff.lcr} :
                            (ofs == OFS_CTRL) ? {27'h0, ctrl_ff} :
                            (ofs == OFS_ILPR) ? {24'h0, ilpr_ff} :
                            (ofs == OFS_IFLS) ? {26'h0, ifls_ff} : 32'h0;

    assign hrdata    = rdata_ff;
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wa_ff      <= 8'h0;
            wr_pend_ff <= 1'b0;
            rdata_ff   <= 32'h0;
        end else begin
            wr_pend_ff <= accept && hwrite;
            wa_ff      <= accept ? ofs : wa_ff;
            rdata_ff   <= rd_acc ? rd_word : rdata_ff;
        end
    end

    // Divisor holding registers feed the live setting only via line control
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ibrd_ff <= 16'h0;
            fbrd_ff <= 6'h0;
            cfg_ff  <= CFG_RESET;
            ctrl_ff <= CTRL_RESET;  // [R01]
            ilpr_ff <= ILPR_RESET;
            ifls_ff <= IFLS_RESET;
        end else begin
            ibrd_ff <= wr_ibrd ? hwdata[15:0] : ibrd_ff;  // [R14]
            fbrd_ff <= wr_fbrd ? hwdata[5:0] : fbrd_ff;  // [R14]
            cfg_ff  <= wr_lcr ? {ibrd_ff, fbrd_ff, hwdata[7:0]} : cfg_ff;  // [R18]
            ctrl_ff <= wr_ctrl ? hwdata[4:0] : ctrl_ff;  // [R01]
            ilpr_ff <= wr_ilpr ? hwdata[7:0] : ilpr_ff;
            ifls_ff <= wr_ifls ? hwdata[5:0] : ifls_ff;
        end
    end

    // Fractional divider: each tick period is div_int cycles, plus one when the
    // fraction accumulator carries, averaging div_int + div_frac/64
    wire [6:0]  bacc_sum = {1'b0, bacc_ff} + {1'b0, cfg_ff.div_frac};
    wire [16:0] blimit   = {1'b0, cfg_ff.div_int} - 17'h1 + {16'h0, bacc_sum[6]};
    wire        os_tick  = cfg_ff.div_int != 16'h0 && {1'b0, bcnt_ff} >= blimit;  // [R15] [R17]

    // Low-power infrared clock; register value 0 divides by 256
    wire        lp_tick  = lpcnt_ff == 8'(ilpr_ff - 8'h1);  // [R22]

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            bcnt_ff  <= 16'h0;
            bacc_ff  <= 6'h0;
            lpcnt_ff <= 8'h0;
        end else begin
            bcnt_ff  <= os_tick ? 16'h0 : 16'(bcnt_ff + 16'h1);
            bacc_ff  <= os_tick ? bacc_sum[5:0] : bacc_ff;
            lpcnt_ff <= lp_tick ? 8'h0 : 8'(lpcnt_ff + 8'h1);
        end
    end

    fifo_buf #(.W(8), .DEPTH(DEPTH)) u_txq (  // [R10]
        .hclk     (hclk),
        .hresetn  (hresetn),
        .one_deep (!cfg_ff.lcr.fen),
        .push     (wr_data),
        .wdata    (hwdata[7:0]),
        .pop      (tx_pop),
        .rdata    (tx_rdata),
        .count    (tx_count),
        .full     (tx_full),
        .empty    (tx_empty)
    );

    fifo_buf #(.W(12), .DEPTH(DEPTH)) u_rxq (  // [R10]
        .hclk     (hclk),
        .hresetn  (hresetn),
        .one_deep (!cfg_ff.lcr.fen),
        .push     (rx_push),
        .wdata    (rx_entry),
        .pop      (rd_pop),
        .rdata    (rx_rdata),
        .count    (rx_count),
        .full     (rx_full),
        .empty    (rx_empty)
    );

    // Transmitter
    wire       tx_go     = ctrl_ff.global_enable && ctrl_ff.transmit_enable;
    assign tx_pop        = tx_state_ff == TX_IDLE && !tx_empty && tx_go;
    wire       tx_bitend = os_tick && tx_sub_ff == SUB_LAST;
    wire [2:0] data_last = 3'(DATA_LAST_BASE + {1'b0, cfg_ff.lcr.wlen});  // [R07]
    wire       tx_end    = tx_bitend && tx_state_ff == TX_STOP && (tx_stopn_ff || !cfg_ff.lcr.stp2);
    wire       tx_line   = (tx_state_ff == TX_START) ? 1'b0 :  // [R04]
                           (tx_state_ff == TX_DATA) ? tx_shift_ff[0] :
                           (tx_state_ff == TX_PARITY) ? tx_par_ff : 1'b1;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            tx_state_ff <= TX_IDLE;
            tx_sub_ff   <= 4'h0;
            tx_bitn_ff  <= 3'h0;
            tx_shift_ff <= 8'h0;
            tx_par_ff   <= 1'b0;
            tx_stopn_ff <= 1'b0;
        end else begin
            tx_sub_ff <= (tx_state_ff == TX_IDLE) ? 4'h0 : (os_tick ? 4'(tx_sub_ff + 4'h1) : tx_sub_ff);  // [R17]
            unique case (tx_state_ff)
                TX_IDLE: begin
                    if (tx_pop) begin
                        tx_shift_ff <= tx_rdata;
                        tx_par_ff   <= parity_bit(tx_rdata, cfg_ff.lcr);  // [R08]
                        tx_bitn_ff  <= 3'h0;
                        tx_stopn_ff <= 1'b0;
                        tx_state_ff <= TX_START;
                    end
                end
                TX_START: begin
                    if (tx_bitend) begin
                        tx_state_ff <= TX_DATA;
                    end
                end
                TX_DATA: begin
                    if (tx_bitend) begin
                        tx_shift_ff <= {1'b0, tx_shift_ff[7:1]};  // [R04]
                        tx_bitn_ff  <= 3'(tx_bitn_ff + 3'h1);
                        if (tx_bitn_ff == data_last) begin
                            tx_state_ff <= cfg_ff.lcr.pen ? TX_PARITY : TX_STOP;  // [R08]
                        end
                    end
                end
                TX_PARITY: begin
                    if (tx_bitend) begin
                        tx_state_ff <= TX_STOP;
                    end
                end
                TX_STOP: begin
                    if (tx_end) begin
                        tx_state_ff <= TX_IDLE;  // [R02]
                    end else if (tx_bitend) begin
                        tx_stopn_ff <= 1'b1;  // [R09]
                    end
                end
            endcase
        end
    end

    // Infrared encoder: normal pulse spans sub-bits 0..2 of a zero bit, low-power
    // pulse lasts three low-power clock periods from the first tick of the bit
    wire lp_load  = os_tick && tx_sub_ff == 4'h0 && tx_state_ff != TX_IDLE && !tx_line;
    wire ir_norm  = tx_state_ff != TX_IDLE && !tx_line && tx_sub_ff < IR_NORMAL_SUBS;  // [R25]
    wire ir_out   = ctrl_ff.ir_lowpower ? lp_pulse_ff != 2'h0 : ir_norm;  // [R21]
    wire nxt_line = ctrl_ff.infrared_codec ? ir_out : (cfg_ff.lcr.brk ? 1'b0 : tx_line);  // [R13] [R20]

    assign serial_out = serial_out_ff;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            lp_pulse_ff   <= 2'h0;
            serial_out_ff <= 1'b1;
        end else begin
            lp_pulse_ff   <= lp_load ? IR_LP_PERIODS : ((lp_tick && lp_pulse_ff != 2'h0) ? 2'(lp_pulse_ff - 2'h1)
                                                                                         : lp_pulse_ff);  // [R21]
            serial_out_ff <= nxt_line;
        end
    end

    // Input synchroniser and infrared decoder; a low pulse stands for one zero bit
    wire rx_in = ctrl_ff.infrared_codec ? (rx_s2_ff && ir_hold_ff == 4'h0) : rx_s2_ff;  // [R20]

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rx_s1_ff   <= 1'b1;
            rx_s2_ff   <= 1'b1;
            ir_hold_ff <= 4'h0;
        end else begin
            rx_s1_ff   <= serial_in;  // [R27]
            rx_s2_ff   <= rx_s1_ff;  // [R27]
            ir_hold_ff <= !rx_s2_ff ? SUB_LAST : ((os_tick && ir_hold_ff != 4'h0) ? 4'(ir_hold_ff - 4'h1) : ir_hold_ff);
        end
    end

    // Receiver
    wire       rx_sample = os_tick && rx_sub_ff == SUB_LAST;  // [R24]
    assign rx_push       = rx_state_ff == RX_STOP && rx_sample;
    wire       rx_brk    = !rx_in && rx_shift_ff == 8'h0 && !rx_pbit_ff;  // [R13]

    assign rx_entry = {ovr_pend_ff, rx_brk, rx_perr_ff, !rx_in, rx_shift_ff};  // [R06] [R24]

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rx_state_ff <= RX_IDLE;
            rx_sub_ff   <= 4'h0;
            rx_bitn_ff  <= 3'h0;
            rx_shift_ff <= 8'h0;
            rx_perr_ff  <= 1'b0;
            rx_pbit_ff  <= 1'b0;
        end else begin
            rx_sub_ff <= (rx_state_ff == RX_IDLE) ? 4'h0 : (os_tick ? 4'(rx_sub_ff + 4'h1) : rx_sub_ff);
            unique case (rx_state_ff)
                RX_IDLE: begin
                    if (ctrl_ff.global_enable && ctrl_ff.receive_enable && !rx_in) begin
                        rx_state_ff <= RX_START;
                    end
                end
                RX_START: begin
                    if (os_tick && rx_sub_ff == START_CHECK) begin
                        rx_state_ff <= rx_in ? RX_IDLE : RX_DATA;  // [R05] [R23]
                        rx_sub_ff   <= 4'h0;
                        rx_bitn_ff  <= 3'h0;
                        rx_shift_ff <= 8'h0;
                        rx_perr_ff  <= 1'b0;
                        rx_pbit_ff  <= 1'b0;
                    end
                end
                RX_DATA: begin
                    if (rx_sample) begin
                        rx_shift_ff[rx_bitn_ff] <= rx_in;
                        rx_bitn_ff              <= 3'(rx_bitn_ff + 3'h1);
                        if (rx_bitn_ff == data_last) begin
                            rx_state_ff <= cfg_ff.lcr.pen ? RX_PARITY : RX_STOP;
                        end
                    end
                end
                RX_PARITY: begin
                    if (rx_sample) begin
                        rx_perr_ff  <= rx_in != parity_bit(rx_shift_ff, cfg_ff.lcr);  // [R08]
                        rx_pbit_ff  <= rx_in;
                        rx_state_ff <= RX_STOP;
                    end
                end
                RX_STOP: begin
                    if (rx_sample) begin
                        rx_state_ff <= rx_brk ? RX_BREAK : RX_IDLE;  // [R02]
                    end
                end
                RX_BREAK: begin
                    // Wait out the break so one break gives one entry
                    if (rx_in) begin
                        rx_state_ff <= RX_IDLE;
                    end
                end
            endcase
        end
    end

    // Overrun: the lost word is flagged on the next word that fits
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ovr_pend_ff   <= 1'b0;
            ovr_sticky_ff <= 1'b0;
        end else begin
            ovr_pend_ff   <= rx_push ? rx_full : ovr_pend_ff;  // [R06]
            ovr_sticky_ff <= (rx_push && rx_full) || (ovr_sticky_ff && !(wr_flag && hwdata[FLAG_OVR_BIT]));
        end
    end

    a_busy_flag: assert property (@(posedge hclk) disable iff (!hresetn)  // [R26]
        $fell(busy) |-> $past(tx_end))
        else $error("busy dropped before the last stop bit");
    a_tx_finish: assert property (@(posedge hclk) disable iff (!hresetn)  // [R02]
        tx_state_ff != TX_IDLE && !tx_end |=> tx_state_ff != TX_IDLE)
        else $error("transmitter stopped mid character");
    a_tx_bit_len: assert property (@(posedge hclk) disable iff (!hresetn)  // [R17]
        tx_state_ff != TX_IDLE && tx_state_ff != $past(tx_state_ff) && $past(tx_state_ff) != TX_IDLE
        |-> $past(os_tick) && $past(tx_sub_ff) == 4'hf)
        else $error("transmit bit not sixteen ticks");
    a_start_low: assert property (@(posedge hclk) disable iff (!hresetn)  // [R04]
        tx_state_ff == TX_START && !ctrl_ff.infrared_codec |-> !nxt_line)
        else $error("start bit not low");
    a_break_out: assert property (@(posedge hclk) disable iff (!hresetn)  // [R13]
        cfg_ff.lcr.brk && !ctrl_ff.infrared_codec |=> !serial_out)
        else $error("break not forced");
    a_start_reject: assert property (@(posedge hclk) disable iff (!hresetn)  // [R23]
        rx_state_ff == RX_START && os_tick && rx_sub_ff == 4'h7 && rx_in |=> rx_state_ff == RX_IDLE)
        else $error("false start accepted");
    a_frame_err: assert property (@(posedge hclk) disable iff (!hresetn)  // [R24]
        rx_push |-> rx_entry.ferr == !rx_s2_ff || ctrl_ff.infrared_codec)
        else $error("framing flag wrong");
    a_lcr_latch: assert property (@(posedge hclk) disable iff (!hresetn)  // [R18]
        !wr_lcr |=> cfg_ff == $past(cfg_ff))
        else $error("setting changed without line control write");
    a_ir_pulse: assert property (@(posedge hclk) disable iff (!hresetn)  // [R25]
        ctrl_ff.infrared_codec && !ctrl_ff.ir_lowpower && tx_state_ff == TX_START
        |-> nxt_line == (tx_sub_ff < 4'h3))
        else $error("infrared zero pulse wrong");
    a_fifo_one_deep: assert property (@(posedge hclk) disable iff (!hresetn)  // [R11]
        !cfg_ff.lcr.fen && $past(!cfg_ff.lcr.fen) && $past(tx_count) <= 1 |-> tx_count <= 1)
        else $error("holding register exceeded one entry");

endmodule : uart_serial

/* bench/serial_partner.sv */
// Remote serial device that drives the block's serial input
`timescale 1ns/10ps
module serial_partner (
    input  wire logic hclk,
    output logic      serial_in
);
    initial serial_in = 1'b1;

    // Sends n bits LSB first, len clocks each, then idles high
    task automatic send(input logic [11:0] bits, input int n, input int len);
        for (int i = 0; i < n; i++) begin
            serial_in <= bits[i];
            repeat (len) @(posedge hclk);
        end
        serial_in <= 1'b1;
        repeat (160) @(posedge hclk);
    endtask : send
endmodule : serial_partner

/* bench/uart_with_fractional_baud_and_ir_bench.sv */
// Bench for the serial port: registers, framing and receive status
`timescale 1ns/10ps
module uart_with_fractional_baud_and_ir_bench;
    import uart_pkg::*;
    typedef struct {logic [7:0] lcr; logic [7:0] data; int n; logic [11:0] frm;} tx_row_t;
    typedef struct {logic [11:0] bits; int n; int len; logic [31:0] exp;} rx_row_t;
    logic        hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp, serial_in, serial_out;
    logic [11:0] haddr, f;
    logic [1:0]  htrans;
    logic [31:0] hwdata, hrdata, rd;
    int          error_cnt = 0;
    int          n_tests = 0;
    // Frames listed from the start bit upward, idle ones above
    tx_row_t tx[5] = '{'{8'h60, 8'ha5, 10, {2'h3, 1'b1, 8'ha5, 1'b0}},
        '{8'h00, 8'h13, 7, {5'h1f, 1'b1, 5'h13, 1'b0}}, '{8'h66, 8'ha5, 11, {2'h3, 1'b0, 8'ha5, 1'b0}},
        '{8'h4a, 8'h01, 11, {3'h7, 1'b0, 7'h01, 1'b0}}, '{8'ha2, 8'h00, 9, {3'h7, 1'b1, 1'b1, 6'h00, 1'b0}}};
    rx_row_t rx[4] = '{'{12'h278, 10, 16, 32'h03c}, '{12'h078, 10, 16, 32'h13c},
        '{12'h000, 10, 16, 32'h500}, '{12'h000, 1, 4, 32'h000}};
    assign hready = hreadyout;
    uart_serial dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .hwrite(hwrite),
        .htrans(htrans), .hsize(3'h2), .hready(hready), .hwdata(hwdata), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .serial_in(serial_in), .serial_out(serial_out));
    serial_partner peer (.hclk(hclk), .serial_in(serial_in));

    task automatic give_verdict();
        $display("Comparisons %0d, mismatches %0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : give_verdict
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            error_cnt++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk
    task automatic edge_ready();
        int t = 0;
        do @(posedge hclk); while (hready !== 1'b1 && ++t < 64);
        if (t >= 64) begin
            error_cnt++;
            give_verdict();
        end
    endtask : edge_ready
    task automatic ahb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        hsel   <= 1'b1;
        htrans <= 2'h2;
        haddr  <= a;
        hwrite <= wr;
        edge_ready();
        htrans <= 2'h0;
        hwdata <= d;
        edge_ready();
        rd = hrdata;
    endtask : ahb
    // Waits for a start bit, then samples mid-bit
    task automatic grab(input int n);
        int t = 0;
        f = '1;
        while (serial_out !== 1'b0 && ++t < 4000) @(posedge hclk);
        if (t >= 4000) begin
            error_cnt++;
            give_verdict();
        end
        repeat (8) @(posedge hclk);
        for (int i = 0; i < n; i++) begin
            f[i] = serial_out;
            repeat (16) @(posedge hclk);
        end
    endtask : grab

    initial begin
        hclk = 1'b0;
        forever #2 hclk = ~hclk;
    end
    initial begin
        #300000;
        error_cnt++;
        give_verdict();
    end
    initial begin
        {hresetn, hsel, haddr, hwrite, htrans, hwdata} = '0;
        repeat (10) @(posedge hclk);
        hresetn <= 1'b1;
        ahb(0, 12'(OFS_CTRL), 0);
        chk("ctrl reset", rd, 32'h18);
        ahb(0, 12'(OFS_IFLS), 0);
        chk("level reset", rd, 32'h12);
        ahb(0, 12'h100, 0);
        chk("unmapped", rd, 0);
        ahb(1, 12'(OFS_IBRD), 1);
        ahb(1, 12'(OFS_FBRD), 0);  // Divisor 1.0 has no fraction
        ahb(1, 12'(OFS_CTRL), 32'h19);
        ahb(1, 12'(OFS_DATA), 32'ha5);
        // No tick before the divisor is latched, so the start bit waits
        repeat (64) @(posedge hclk);
        chk("start held", {31'h0, serial_out}, 0);
        ahb(0, 12'(OFS_FLAG), 0);
        chk("busy flags", rd & 32'h14, 32'h14);
        foreach (tx[i]) begin
            ahb(1, 12'(OFS_CTRL), 32'h18);
            ahb(1, 12'(OFS_LCR), {24'h0, tx[i].lcr});
            ahb(1, 12'(OFS_CTRL), 32'h19);
            if (i > 0) ahb(1, 12'(OFS_DATA), {24'h0, tx[i].data});
            grab(tx[i].n);
            chk("frame", {20'h0, f}, {20'h0, tx[i].frm});
        end
        ahb(1, 12'(OFS_CTRL), 32'h18);
        ahb(1, 12'(OFS_LCR), 32'h61);
        repeat (2) @(posedge hclk);
        chk("break out", {31'h0, serial_out}, 0);
        ahb(1, 12'(OFS_LCR), 32'h60);
        ahb(1, 12'(OFS_CTRL), 32'h1b);
        ahb(1, 12'(OFS_DATA), 0);
        // Start bit is a zero: high for its first three ticks only
        repeat (4) @(posedge hclk);
        chk("ir pulse", {31'h0, serial_out}, 1);
        repeat (3) @(posedge hclk);
        chk("ir pulse end", {31'h0, serial_out}, 0);
        ahb(1, 12'(OFS_CTRL), 32'h18);
        ahb(1, 12'(OFS_CTRL), 32'h19);
        foreach (rx[i]) begin
            peer.send(rx[i].bits, rx[i].n, rx[i].len);
            ahb(0, 12'(OFS_DATA), 0);
            chk("rx word", rd, rx[i].exp);
        end
        give_verdict();
    end
endmodule : uart_with_fractional_baud_and_ir_bench
